//--- pkg/hpm_pkg.sv
/*
 * hpm_pkg: constants, modes and carriers for the host and panel pin mux.
 * assumes: all users write hpm_pkg::name, nothing is imported.
 */
`default_nettype none
package hpm_pkg;

    // strap pattern decode results
    typedef enum logic [2:0] {
        HPM_MODE_RSV   = 3'b000,
        HPM_MODE_SYNA  = 3'b001,
        HPM_MODE_SYNB  = 3'b010,
        HPM_MODE_ASA   = 3'b011,
        HPM_MODE_ASB   = 3'b100,
        HPM_MODE_GENA  = 3'b101,
        HPM_MODE_GENB  = 3'b110
    } hpm_mode_t;

    // panel type select
    typedef enum logic [2:0] {
        HPM_PANEL_ACTIVE  = 3'b000,
        HPM_PANEL_PASSIVE = 3'b001,
        HPM_PANEL_COLFMT1 = 3'b010
    } hpm_panel_t;

    typedef struct packed {
        hpm_mode_t mode;
        logic      big_endian;
        logic      reserved;
    } hpm_cfg_t;

    // host side response pin group
    typedef struct packed {
        logic wait_req_n;
        logic dev_ready_n;
        logic transfer_ack_out_n;
        logic size_ack_bit1_out_n;
    } hpm_resp_t;

    localparam logic [3:0] HPM_CNF_SYNA_BE  = 4'h8;
    localparam logic [3:0] HPM_CNF_SYNA_LE  = 4'h0;
    localparam logic [3:0] HPM_CNF_SYNB_BE  = 4'h9;
    localparam logic [3:0] HPM_CNF_SYNB_LE  = 4'h1;
    localparam logic [3:0] HPM_CNF_ASA_BE   = 4'hB;
    localparam logic [3:0] HPM_CNF_ASB_BE   = 4'hD;
    localparam logic [3:0] HPM_CNF_GEN_BE   = 4'hF;
    localparam logic [3:0] HPM_CNF_GEN_LE   = 4'h7;

    // apb register map
    localparam logic [7:0] HPM_ADDR_CTRL    = 8'h00;
    localparam logic [7:0] HPM_ADDR_PWRSAVE = 8'h0C;
    localparam logic [7:0] HPM_ADDR_GPIO    = 8'h10;
    localparam logic [7:0] HPM_ADDR_STATUS  = 8'h14;

    // ctrl register fields
    localparam int HPM_CTRL_PANEL_LSB = 0;
    localparam int HPM_CTRL_PWR_BIT   = 4;
    localparam int HPM_CTRL_INV_BIT   = 5;
    // hardware power save select, bit 2 of the power save register
    localparam int HPM_PS_SEL_BIT     = 2;
    localparam int HPM_GPIO_OE_LSB    = 8;

    localparam logic [31:0] HPM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] HPM_PS_RST   = 32'h0000_0000;
    localparam logic [31:0] HPM_GPIO_RST = 32'h0000_0000;

endpackage
`default_nettype wire

//--- logic/hpm_strap_latch.sv
/*
 * hpm_strap_latch: samples straps during reset and decodes the host mode.
 * assumes: straps are static board ties, so no synchroniser is needed.
 */
`default_nettype none
module hpm_strap_latch (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [3:0]       config_straps_i,
    input  wire logic             bus_start_in_i,
    output var  hpm_pkg::hpm_cfg_t cfg_o
);
    hpm_pkg::hpm_cfg_t dec_d;
    hpm_pkg::hpm_cfg_t cfg_q;

    always_comb begin
        dec_d.mode       = hpm_pkg::HPM_MODE_RSV;
        dec_d.big_endian = config_straps_i[3];
        dec_d.reserved   = 1'b0;
        if (config_straps_i == hpm_pkg::HPM_CNF_SYNA_BE ||
            config_straps_i == hpm_pkg::HPM_CNF_SYNA_LE) begin
            dec_d.mode = hpm_pkg::HPM_MODE_SYNB;
        end else if (config_straps_i == hpm_pkg::HPM_CNF_SYNB_BE ||
                     config_straps_i == hpm_pkg::HPM_CNF_SYNB_LE) begin
            dec_d.mode = hpm_pkg::HPM_MODE_SYNA;
        end else if (config_straps_i == hpm_pkg::HPM_CNF_ASA_BE) begin
            dec_d.mode = hpm_pkg::HPM_MODE_ASA;
        end else if (config_straps_i == hpm_pkg::HPM_CNF_ASB_BE) begin
            dec_d.mode = hpm_pkg::HPM_MODE_ASB;
        end else if (config_straps_i == hpm_pkg::HPM_CNF_GEN_BE && !bus_start_in_i) begin
            dec_d.mode = hpm_pkg::HPM_MODE_GENA;
        end else if (config_straps_i == hpm_pkg::HPM_CNF_GEN_LE && !bus_start_in_i) begin
            dec_d.mode = hpm_pkg::HPM_MODE_GENA;
        end else if (config_straps_i == hpm_pkg::HPM_CNF_GEN_LE && bus_start_in_i) begin
            dec_d.mode = hpm_pkg::HPM_MODE_GENB;
        end else begin
            dec_d.reserved = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cfg_q <= dec_d;
        end
    end

    assign cfg_o = cfg_q;
endmodule
`default_nettype wire

//--- logic/hpm_panel_mux.sv
/*
 * hpm_panel_mux: steers panel data, display enable and gpio pins by panel type.
 * assumes: inputs come from registers on sys_clk_i; outputs are registered above.
 */
`default_nettype none
module hpm_panel_mux (
    input  wire logic               panel_active_i,
    input  wire hpm_pkg::hpm_panel_t panel_type_i,
    input  wire logic [3:0]         panel_data_hi_i,
    input  wire logic               disp_en_i,
    input  wire logic               bias_i,
    input  wire logic               shift2_i,
    input  wire logic [3:0]         gpio_out_i,
    input  wire logic [3:0]         gpio_oe_i,
    output logic [3:0]              pin_out_o,
    output logic [3:0]              pin_oe_o,
    output logic                    display_enable_out_o
);
    logic tft;

    assign tft = (panel_type_i == hpm_pkg::HPM_PANEL_ACTIVE) && panel_active_i;

    always_comb begin
        pin_out_o = gpio_out_i;
        pin_oe_o  = gpio_oe_i;
        if (tft) begin
            pin_out_o = panel_data_hi_i;
            pin_oe_o  = 4'hF;
        end
    end

    always_comb begin
        display_enable_out_o = 1'b0;
        if (panel_type_i == hpm_pkg::HPM_PANEL_ACTIVE) begin
            display_enable_out_o = disp_en_i;
        end else if (panel_type_i == hpm_pkg::HPM_PANEL_COLFMT1) begin
            display_enable_out_o = shift2_i;
        end else begin
            display_enable_out_o = bias_i;
        end
    end
endmodule
`default_nettype wire

//--- logic/hpm_top.sv
/*
 * hpm_top: host response and panel pin function mux with an apb register file.
 * assumes: host pins and gpio pins are asynchronous and synchronised here;
 * panel timing and data come from logic on sys_clk_i.
 */
// The APB slave port and the address map were chosen for this implementation.
`default_nettype none
module hpm_top #(
    parameter int GPIO_W = 5
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [3:0]  config_straps_i,
    input  wire logic        bus_start_in_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic        upper_read_n_i,
    input  wire logic        data_ready_i,
    output logic             bus_resp_o,
    output logic             bus_resp_oe_o,
    output logic             low_byte_read_cmd_o,
    output logic             high_byte_read_cmd_o,
    output logic             transfer_size_bit1_o,
    input  wire logic [3:0]  panel_data_hi_i,
    input  wire logic        panel_active_i,
    input  wire logic        disp_en_i,
    input  wire logic        bias_i,
    input  wire logic        shift2_i,
    input  wire logic [4:0]  gpio_pin_i,
    output logic      [4:0]  gpio_pin_o,
    output logic      [4:0]  gpio_pin_oe_o,
    output logic             display_enable_out_o,
    output logic             panel_power_ctrl_o,
    output logic             inverse_video_o,
    output logic             hw_power_save_o,
    output logic             cfg_reserved_o
);
    // pin groups are fixed at five bits, so refuse anything else at elaboration
    if (GPIO_W != 5) begin : g_bad_width
        $error("hpm_top supports exactly five gpio bits");
    end

    hpm_pkg::hpm_cfg_t  cfg;
    hpm_pkg::hpm_resp_t resp_d;
    logic [31:0]        ctrl_q;
    logic [31:0]        ps_q;
    logic [31:0]        gpio_q;
    logic [31:0]        rdata_d;
    logic               addr_ok;
    logic               wr_en;
    logic [2:0]         host_s1_q;
    logic [2:0]         host_s2_q;
    logic [4:0]         gpin_s1_q;
    logic [4:0]         gpin_s2_q;
    logic [3:0]         pmux_out;
    logic [3:0]         pmux_oe;
    logic               de_mux;
    logic               rd_n;
    logic               rd1_n;
    logic               rdy;
    logic               ps_sel;
    logic               tft;

    hpm_strap_latch u_strap (
        .sys_clk_i       (sys_clk_i),
        .rst_b_i         (rst_b_i),
        .config_straps_i (config_straps_i),
        .bus_start_in_i  (bus_start_in_i),
        .cfg_o           (cfg)
    );

    // host pins cross in through two flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            host_s1_q <= 3'h7;
            host_s2_q <= 3'h7;
        end else begin
            host_s1_q <= {data_ready_i, upper_read_n_i, read_strobe_n_i};
            host_s2_q <= host_s1_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            gpin_s1_q <= 5'h00;
            gpin_s2_q <= 5'h00;
        end else begin
            gpin_s1_q <= gpio_pin_i;
            gpin_s2_q <= gpin_s1_q;
        end
    end

    assign rd_n   = host_s2_q[0];
    assign rd1_n  = host_s2_q[1];
    assign rdy    = host_s2_q[2];
    assign ps_sel = ps_q[hpm_pkg::HPM_PS_SEL_BIT];
    assign tft    = (hpm_pkg::hpm_panel_t'(ctrl_q[2:0]) == hpm_pkg::HPM_PANEL_ACTIVE)
                    && panel_active_i;

    // apb slave, zero wait state
    assign wr_en = psel_i && penable_i && pwrite_i;

    always_comb begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        if (paddr_i == hpm_pkg::HPM_ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end else if (paddr_i == hpm_pkg::HPM_ADDR_PWRSAVE) begin
            rdata_d = ps_q;
        end else if (paddr_i == hpm_pkg::HPM_ADDR_GPIO) begin
            rdata_d = {gpio_q[31:5], gpin_s2_q};
        end else if (paddr_i == hpm_pkg::HPM_ADDR_STATUS) begin
            rdata_d = {27'h0, cfg.reserved, cfg.big_endian, cfg.mode};
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= hpm_pkg::HPM_CTRL_RST;
            ps_q   <= hpm_pkg::HPM_PS_RST;
            gpio_q <= hpm_pkg::HPM_GPIO_RST;
        end else if (wr_en && addr_ok) begin
            if (paddr_i == hpm_pkg::HPM_ADDR_CTRL) begin
                ctrl_q <= pwdata_i;
            end else if (paddr_i == hpm_pkg::HPM_ADDR_PWRSAVE) begin
                ps_q <= pwdata_i;
            end else if (paddr_i == hpm_pkg::HPM_ADDR_GPIO) begin
                gpio_q <= pwdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !addr_ok;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rdata_d : 32'h0000_0000;
        end
    end

    // response role per mode; pins are active low, high is idle
    always_comb begin
        resp_d = '1;
        resp_d.wait_req_n          = rdy;
        resp_d.dev_ready_n         = !rdy;
        resp_d.transfer_ack_out_n  = !rdy;
        resp_d.size_ack_bit1_out_n = !rdy;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            bus_resp_o    <= 1'b1;
            bus_resp_oe_o <= 1'b0;
        end else begin
            bus_resp_oe_o <= !cfg.reserved;
            case (cfg.mode)
                hpm_pkg::HPM_MODE_SYNA: begin
                    bus_resp_o <= resp_d.wait_req_n;
                end
                hpm_pkg::HPM_MODE_GENA,
                hpm_pkg::HPM_MODE_GENB: begin
                    bus_resp_o <= resp_d.wait_req_n;
                end
                hpm_pkg::HPM_MODE_SYNB: begin
                    bus_resp_o <= resp_d.dev_ready_n;
                end
                hpm_pkg::HPM_MODE_ASA: begin
                    bus_resp_o <= resp_d.transfer_ack_out_n;
                end
                hpm_pkg::HPM_MODE_ASB: begin
                    bus_resp_o <= resp_d.size_ack_bit1_out_n;
                end
                default: begin
                    bus_resp_o <= 1'b1;
                end
            endcase
        end
    end

    // read strobe meaning per mode, outputs active high
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            low_byte_read_cmd_o  <= 1'b0;
            high_byte_read_cmd_o <= 1'b0;
            transfer_size_bit1_o <= 1'b0;
        end else begin
            low_byte_read_cmd_o  <= 1'b0;
            high_byte_read_cmd_o <= 1'b0;
            transfer_size_bit1_o <= 1'b0;
            case (cfg.mode)
                hpm_pkg::HPM_MODE_SYNA,
                hpm_pkg::HPM_MODE_SYNB: begin
                    low_byte_read_cmd_o  <= !rd_n;
                    high_byte_read_cmd_o <= !rd_n;
                end
                hpm_pkg::HPM_MODE_ASB: begin
                    transfer_size_bit1_o <= rd_n;
                end
                hpm_pkg::HPM_MODE_GENA: begin
                    low_byte_read_cmd_o  <= !rd_n;
                    high_byte_read_cmd_o <= !rd1_n;
                end
                hpm_pkg::HPM_MODE_GENB: begin
                    low_byte_read_cmd_o  <= !rd_n;
                    high_byte_read_cmd_o <= !rd_n;
                end
                default: begin
                    low_byte_read_cmd_o  <= 1'b0;
                end
            endcase
        end
    end

    hpm_panel_mux u_panel (
        .panel_active_i       (panel_active_i),
        .panel_type_i         (hpm_pkg::hpm_panel_t'(ctrl_q[2:0])),
        .panel_data_hi_i      (panel_data_hi_i),
        .disp_en_i            (disp_en_i),
        .bias_i               (bias_i),
        .shift2_i             (shift2_i),
        .gpio_out_i           (gpio_q[4:1]),
        .gpio_oe_i            (gpio_q[12:9]),
        .pin_out_o            (pmux_out),
        .pin_oe_o             (pmux_oe),
        .display_enable_out_o (de_mux)
    );

    // panel and gpio pins registered
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            gpio_pin_o           <= 5'h00;
            gpio_pin_oe_o        <= 5'h00;
            display_enable_out_o <= 1'b0;
            panel_power_ctrl_o   <= 1'b0;
            inverse_video_o      <= 1'b0;
            hw_power_save_o      <= 1'b0;
            cfg_reserved_o       <= 1'b0;
        end else begin
            gpio_pin_o[0]        <= gpio_q[0];
            gpio_pin_oe_o[0]     <= gpio_q[hpm_pkg::HPM_GPIO_OE_LSB] && !ps_sel;
            hw_power_save_o      <= ps_sel && gpin_s2_q[0];
            gpio_pin_o[4:1]      <= pmux_out;
            gpio_pin_oe_o[4:1]   <= pmux_oe;
            inverse_video_o      <= tft ? 1'b0
                                    : (ctrl_q[hpm_pkg::HPM_CTRL_INV_BIT] && gpin_s2_q[4]);
            display_enable_out_o <= de_mux;
            panel_power_ctrl_o   <= ctrl_q[hpm_pkg::HPM_CTRL_PWR_BIT];
            cfg_reserved_o       <= cfg.reserved;
        end
    end
endmodule
`default_nettype wire

//--- verification/hpm_host_model.sv
/* hpm_host_model: host bus strobes and gpio pad levels seen by hpm_top.
   assumes: the bench sets mode_i to match the straps that it ties. */
`default_nettype none
module hpm_host_model (
    input  wire logic               sys_clk_i,
    input  wire hpm_pkg::hpm_mode_t mode_i,
    input  wire logic               rd_req_i,
    input  wire logic               size1_i,
    input  wire logic [4:0]         pin_out_i,
    input  wire logic [4:0]         pin_oe_i,
    input  wire logic [4:0]         ext_en_i,
    input  wire logic [4:0]         ext_val_i,
    output logic                    strobe_n_o,
    output logic                    upper_n_o,
    output logic [4:0]              level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge sys_clk_i) begin
        case (mode_i)
            hpm_pkg::HPM_MODE_ASB: strobe_n_o <= size1_i;
            // pin tied high
            hpm_pkg::HPM_MODE_ASA: strobe_n_o <= 1'b1;
            default: strobe_n_o <= !rd_req_i;
        endcase
    end
    assign upper_n_o = 1'b1;
    // unused pads are tied high, so a released pin reads one unless ext_en drives ext_val onto it
    assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & (~ext_en_i | ext_val_i));
endmodule
`default_nettype wire

//--- verification/hpm_top_props.sv
/* hpm_top_props: port assertions for the host and panel pin mux.
   assumes: bound into hpm_top; one clock, synchronous active-low reset. */
`default_nettype none
module hpm_top_props (
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic [3:0]  config_straps_i,
    input wire logic        bus_start_in_i,
    input wire logic        read_strobe_n_i,
    input wire logic        upper_read_n_i,
    input wire logic        data_ready_i,
    input wire logic        bus_resp_o,
    input wire logic        bus_resp_oe_o,
    input wire logic        low_byte_read_cmd_o,
    input wire logic        high_byte_read_cmd_o,
    input wire logic        transfer_size_bit1_o,
    input wire logic [4:0]  gpio_pin_oe_o,
    input wire logic        panel_power_ctrl_o,
    input wire logic        cfg_reserved_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] mode_q;
    logic [2:0] cnt_q;
    logic       ok;

    default clocking cb @(posedge sys_clk_i);
    endclocking

    // own strap decode, last edge in reset wins
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            casez ({config_straps_i, bus_start_in_i})
                5'b?000?: mode_q <= 3'h2;
                5'b?001?: mode_q <= 3'h1;
                5'b1011?: mode_q <= 3'h3;
                5'b1101?: mode_q <= 3'h4;
                5'b?1110: mode_q <= 3'h5;
                5'b01111: mode_q <= 3'h6;
                default:  mode_q <= 3'h0;
            endcase
        end
    end

    // host pins pass a sync pipe, so wait it out after reset
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h4) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
    assign ok = rst_b_i && cnt_q == 3'h4;

    sequence s_idle;
        bus_resp_o && !bus_resp_oe_o && !pready_o && !panel_power_ctrl_o
        && gpio_pin_oe_o == 5'h00;
    endsequence
    sequence s_pwr_wr;
        psel_i && !penable_i ##1 psel_i && penable_i && pwrite_i && pwdata_i[4]
        && paddr_i == hpm_pkg::HPM_ADDR_CTRL;
    endsequence

    property p_rst;
        !rst_b_i |=> s_idle;
    endproperty
    property p_wait;
        disable iff (!rst_b_i) ok && mode_q inside {3'h1, 3'h5, 3'h6}
        |-> bus_resp_o == $past(data_ready_i, 3);
    endproperty
    property p_ready;
        disable iff (!rst_b_i) ok && mode_q == 3'h2 |-> bus_resp_o == !$past(data_ready_i, 3);
    endproperty
    property p_tack;
        disable iff (!rst_b_i) ok && mode_q == 3'h3 |-> bus_resp_o == !$past(data_ready_i, 3);
    endproperty
    property p_sack;
        disable iff (!rst_b_i) ok && mode_q == 3'h4 |-> bus_resp_o == !$past(data_ready_i, 3);
    endproperty
    property p_size;
        disable iff (!rst_b_i) ok
        |-> transfer_size_bit1_o == (mode_q == 3'h4 && $past(read_strobe_n_i, 3));
    endproperty
    property p_lowrd;
        disable iff (!rst_b_i) ok && mode_q == 3'h5
        |-> low_byte_read_cmd_o == !$past(read_strobe_n_i, 3)
            && high_byte_read_cmd_o == !$past(upper_read_n_i, 3);
    endproperty
    property p_pwr;
        disable iff (!rst_b_i) s_pwr_wr |=> ##1 panel_power_ctrl_o;
    endproperty
    property p_hold;
        disable iff (!rst_b_i) ok |-> $stable(cfg_reserved_o) && bus_resp_oe_o == !cfg_reserved_o;
    endproperty
    property p_res;
        disable iff (!rst_b_i) ok |-> cfg_reserved_o == (mode_q == 3'h0);
    endproperty

    a_rst: assert property (p_rst) else $error("outputs not idle in reset");
    a_wait: assert property (p_wait) else $error("wait response wrong");
    a_ready: assert property (p_ready) else $error("ready response wrong");
    a_tack: assert property (p_tack) else $error("transfer ack wrong");
    a_sack: assert property (p_sack) else $error("size ack wrong");
    a_size: assert property (p_size) else $error("size bit wrong");
    a_lowrd: assert property (p_lowrd) else $error("byte read cmd wrong");
    a_pwr: assert property (p_pwr) else $error("panel power not on");
    a_hold: assert property (p_hold) else $error("config changed");
    a_res: assert property (p_res) else $error("reserved decode wrong");
endmodule

bind hpm_top hpm_top_props u_hpm_top_props (
    .sys_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .config_straps_i, .bus_start_in_i, .read_strobe_n_i, .upper_read_n_i,
    .data_ready_i, .bus_resp_o, .bus_resp_oe_o, .low_byte_read_cmd_o,
    .high_byte_read_cmd_o, .transfer_size_bit1_o, .gpio_pin_oe_o,
    .panel_power_ctrl_o, .cfg_reserved_o);
`default_nettype wire

//--- verification/hpm_top_test.sv
/* hpm_top_test: apb and pin bench for the host and panel pin mux.
   assumes: hpm_top, hpm_host_model and the bound checker are compiled. */
`default_nettype none
module hpm_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk_i = 1'b0;
    logic        rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd, m;
    logic [3:0]  config_straps_i, panel_data_hi_i;
    logic        bus_start_in_i, read_strobe_n_i, upper_read_n_i, data_ready_i;
    logic        bus_resp_o, bus_resp_oe_o, low_byte_read_cmd_o, high_byte_read_cmd_o;
    logic        transfer_size_bit1_o, panel_active_i, disp_en_i, bias_i, shift2_i;
    logic [4:0]  gpio_pin_i, gpio_pin_o, gpio_pin_oe_o, ext_en, ext_val;
    logic        display_enable_out_o, panel_power_ctrl_o, inverse_video_o;
    logic        hw_power_save_o, cfg_reserved_o, rd_req, size1;
    logic [15:0] e;
    int          fail_count, tests_run;
    hpm_pkg::hpm_mode_t cur_mode;
    // straps, bus start, expected status {reserved, big endian, mode}
    localparam logic [15:0] MODES [13] = '{16'hF110, 16'h3010, 16'hA110, 16'h6110,
        16'h800A, 16'h0002, 16'h9009, 16'h1001, 16'hB00B, 16'hD00C, 16'hF00D,
        16'h7005, 16'h7106};

    hpm_top u_hpm_top (
        .sys_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .config_straps_i, .bus_start_in_i,
        .read_strobe_n_i, .upper_read_n_i, .data_ready_i, .bus_resp_o, .bus_resp_oe_o,
        .low_byte_read_cmd_o, .high_byte_read_cmd_o, .transfer_size_bit1_o,
        .panel_data_hi_i, .panel_active_i, .disp_en_i, .bias_i, .shift2_i, .gpio_pin_i,
        .gpio_pin_o, .gpio_pin_oe_o, .display_enable_out_o, .panel_power_ctrl_o,
        .inverse_video_o, .hw_power_save_o, .cfg_reserved_o);

    hpm_host_model u_hpm_host_model (
        .sys_clk_i, .mode_i(cur_mode), .rd_req_i(rd_req), .size1_i(size1),
        .pin_out_i(gpio_pin_o), .pin_oe_i(gpio_pin_oe_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .strobe_n_o(read_strobe_n_i), .upper_n_o(upper_read_n_i),
        .level_o(gpio_pin_i));

    always #5 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1);
        chk(n, 1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic restart(input logic [3:0] s, input logic b);
        @(posedge sys_clk_i);
        rst_b_i         <= 1'b0;
        config_straps_i <= s;
        bus_start_in_i  <= b;
        repeat (5) @(posedge sys_clk_i);
        chk({bus_resp_o, bus_resp_oe_o, panel_power_ctrl_o, gpio_pin_oe_o}, 8'h80);
        rst_b_i         <= 1'b1;
        @(posedge sys_clk_i);
        config_straps_i <= ~s;
        bus_start_in_i  <= ~b;
    endtask

    initial begin
        {rst_b_i, psel_i, penable_i, pwrite_i, bus_start_in_i, data_ready_i} = '0;
        {panel_active_i, disp_en_i, bias_i, shift2_i, rd_req, size1} = '0;
        {paddr_i, pwdata_i, config_straps_i, panel_data_hi_i, ext_en, ext_val} = '0;
        cur_mode = hpm_pkg::HPM_MODE_RSV;
        for (int i = 0; i < 13; i++) begin
            e        = MODES[i];
            cur_mode = hpm_pkg::hpm_mode_t'(e[2:0]);
            m        = e[4] ? 32'h17 : 32'h1F;
            restart(e[15:12], e[8]);
            apb(1'b0, hpm_pkg::HPM_ADDR_STATUS, 32'h0);
            chk(rd & m, {24'h0, e[7:0]} & m);
            chk(bus_resp_oe_o, !e[4]);
            for (int v = 0; v < 2; v++) begin
                data_ready_i <= v[0];
                size1        <= v[0];
                rd_req       <= v[0];
                repeat (6) @(posedge sys_clk_i);
                case (e[2:0])
                    3'h1, 3'h5, 3'h6: chk(bus_resp_o, v[0]);
                    3'h2: chk(bus_resp_o, !v[0]);
                    3'h3: chk(bus_resp_o, !v[0]);
                    3'h4: chk(bus_resp_o, !v[0]);
                    default: ;
                endcase
                chk(transfer_size_bit1_o, e[2:0] == 3'h4 && v[0]);
                if (e[2:0] == 3'h5) chk({low_byte_read_cmd_o, high_byte_read_cmd_o}, v * 2);
            end
        end
        apb(1'b1, hpm_pkg::HPM_ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, hpm_pkg::HPM_ADDR_STATUS, 32'h0);
        chk(rd, 32'h06);
        apb(1'b0, hpm_pkg::HPM_ADDR_CTRL, 32'h0);
        chk(rd, hpm_pkg::HPM_CTRL_RST);
        apb(1'b0, hpm_pkg::HPM_ADDR_PWRSAVE, 32'h0);
        chk(rd, hpm_pkg::HPM_PS_RST);
        apb(1'b0, 8'h04, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        // a wrong input selected leaves the output at the other level
        for (int t = 0; t < 3; t++) begin
            apb(1'b1, hpm_pkg::HPM_ADDR_CTRL, t);
            for (int p = 0; p < 2; p++) begin
                {shift2_i, bias_i, disp_en_i} <= p ? (3'h1 << t) : ~(3'h1 << t);
                repeat (3) @(posedge sys_clk_i);
                chk(display_enable_out_o, p[0]);
            end
        end
        apb(1'b1, hpm_pkg::HPM_ADDR_CTRL, 32'h0);
        panel_active_i  <= 1'b1;
        panel_data_hi_i <= 4'hA;
        repeat (3) @(posedge sys_clk_i);
        chk({gpio_pin_oe_o, gpio_pin_o}, {5'h1E, 5'h14});
        apb(1'b1, hpm_pkg::HPM_ADDR_CTRL, 32'h1);
        apb(1'b1, hpm_pkg::HPM_ADDR_GPIO, 32'h1F0A);
        repeat (4) @(posedge sys_clk_i);
        chk({gpio_pin_oe_o, gpio_pin_o}, {5'h1F, 5'h0A});
        apb(1'b0, hpm_pkg::HPM_ADDR_GPIO, 32'h0);
        chk(rd, 32'h1F0A);
        apb(1'b1, hpm_pkg::HPM_ADDR_GPIO, 32'h0F00);
        apb(1'b1, hpm_pkg::HPM_ADDR_CTRL, 32'h31);
        ext_en  <= 5'h11;
        ext_val <= 5'h00;
        repeat (4) @(posedge sys_clk_i);
        chk({panel_power_ctrl_o, inverse_video_o}, 2'b10);
        chk({hw_power_save_o, gpio_pin_oe_o[0]}, 2'b01);
        ext_val <= 5'h11;
        apb(1'b1, hpm_pkg::HPM_ADDR_PWRSAVE, 32'h4);
        repeat (5) @(posedge sys_clk_i);
        chk({inverse_video_o, hw_power_save_o, gpio_pin_oe_o[0]}, 3'b110);
        ext_val <= 5'h00;
        repeat (4) @(posedge sys_clk_i);
        chk(hw_power_save_o, 1'b0);
        stop_test();
    end

    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
